// ### rtl/mcfp_consts.svh
// constants for the multi-processor fault propagation block
`ifndef MCFP_CONSTS_SVH
`define MCFP_CONSTS_SVH
`define MCFP_CODE_NONE 16'h0000
`define MCFP_CODE_SYS_HALT 16'd7000
`define MCFP_CODE_PEER_ERR 16'd7020
`define MCFP_CODE_MOTION 16'd10000
`define MCFP_ADR_CTRL 4'h0
`define MCFP_ADR_STATUS 4'h1
`define MCFP_ADR_IRQ 4'h2
`define MCFP_ADR_MASK 4'h3
`define MCFP_ADR_CODE 4'h4
`define MCFP_ADR_CAUSE 4'h5
`define MCFP_ADR_FAULTCPU 4'h6
`define MCFP_ADR_EVENT 4'h7
`define MCFP_HALTSEL_RST 3'h7
`define MCFP_IRQ_SYSHALT 0
`define MCFP_IRQ_PEERERR 1
`define MCFP_IRQ_LOCAL 2
`define MCFP_IRQ_PROG 3
`define MCFP_IRQ_W 4
`define MCFP_CPU_FIRST 2'd0
`endif

// ### rtl/mcfp_pkg.sv
// types for the multi-processor fault propagation block
package mcfp_pkg;
  typedef enum logic [3:0] {
    MCFP_RUN = 4'h1,
    MCFP_STOPPED = 4'h2,
    MCFP_HALTED = 4'h4,
    MCFP_CFG_DEAD = 4'h8
  } mcfp_state_t;
  typedef enum logic [2:0] {
    MCFP_C_NONE = 3'h0,
    MCFP_C_SYSCFG = 3'h1,
    MCFP_C_WDT = 3'h2,
    MCFP_C_DIAG_FATAL = 3'h3,
    MCFP_C_DIAG_CONT = 3'h4,
    MCFP_C_PROG = 3'h5,
    MCFP_C_PEER = 3'h6
  } mcfp_cause_t;
  typedef struct packed {
    logic [3:0] halt;
    logic [3:0] resetting;
  } mcfp_peer_t;
  typedef struct packed {
    mcfp_state_t st;
    logic [2:0] haltSel;
    logic runReq;
    logic outForceOff;
    logic sysHalt;
    logic peerErr;
    logic [15:0] code;
    mcfp_cause_t cause;
    logic [1:0] faultCpu;
    logic [3:0] irqSt;
    logic [3:0] irqMask;
    logic [7:0] prog;
    logic ack;
    logic [31:0] dat;
    logic [3:0] haltS1;
    logic [3:0] haltS2;
    logic [3:0] haltS3;
    logic [3:0] rstS1;
    logic [3:0] rstS2;
    logic [3:0] rstS3;
    logic [3:0] haltV;
    logic [3:0] rstV;
  } mcfp_reg_t;
endpackage

// ### rtl/mcfp_fault_unit.sv
// fault propagation and error response for one processor of up to four
//
// Summary of operation
// - A halt of processor 1 makes all others raise code 7000 and stop.
// - A reset from processor 1 or power cycle resets all; each stays stopped until runReq is set.
// - Processors 2 to 4 each have a halt-all selection, set by default.
// - A peer halt with its selection set raises code 7000 and stops.
// - A peer halt with its selection clear raises code 7020, runs on.
// - A processor that stops on a peer halt raises the system halt.
// - The recorded fault processor may be a cascade, not the first.
// - A config error blocks running, forces outputs off, spares peers.
// - A watchdog timeout forces all physical outputs off.
// - A fatal self-diagnosis error halts; peers follow selection.
// - A peer halt with its selection set acts as stop with the run-state flag clear.
// - A continuable self-diagnosis error leaves operation running.
// - Program, axis and setting errors stop only that program.
// - During continuable program errors outputs keep their values.
// - A motion fault reports code 10000, detail in a cause register.
// - A lone reset of processor 2 to 4 raises code 7000, regardless.
//
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/10ps
module mcfp_fault_unit #(
  parameter logic [1:0] SELF_ID = 2'd1,
  parameter int NPROG = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic wbCycI,
  input wire logic wbStbI,
  input wire logic wbWeI,
  input wire logic [3:0] wbAdrI,
  input wire logic [3:0] wbSelI,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAckO,
  input wire mcfp_pkg::mcfp_peer_t peerIn,
  output logic selfHaltOut,
  input wire logic errSysCfg,
  input wire logic errWdt,
  input wire logic errDiagFatal,
  input wire logic errDiagCont,
  input wire logic [NPROG-1:0] errProg,
  output logic runStateFlag,
  output logic outputsForceOff,
  output logic [NPROG-1:0] progStop,
  output logic [15:0] errCode,
  output logic irq
);
  `include "mcfp_consts.svh"
  mcfp_pkg::mcfp_reg_t r_q, r_d;
  logic wbHit;
  logic [3:0] irqSet;
  logic [3:0] peerHaltSeen;
  logic [3:0] peerRstSeen;
  logic [3:0] wantAll;
  logic anyHaltAll;
  logic anyPeerCont;
  logic [1:0] firstCpu;

  assign wbHit = wbCycI && wbStbI && !r_q.ack;

  // three-stage sampling of peer lines; a change counts once stages agree
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gPeer
      assign peerHaltSeen[g] = r_q.haltV[g] && (g != SELF_ID);
      assign peerRstSeen[g] = r_q.rstV[g] && (g != SELF_ID) && (g != 0);
      // processor 1 always stops everyone; others by selection
      if (g == 0) begin : gMaster
        assign wantAll[g] = 1'b1;
      end else begin : gSel
        assign wantAll[g] = r_q.haltSel[g-1];
      end
    end
  endgenerate

  assign anyHaltAll = |(peerHaltSeen & wantAll) || (|peerRstSeen);
  assign anyPeerCont = |(peerHaltSeen & ~wantAll);

  always_comb begin
    firstCpu = `MCFP_CPU_FIRST;
    for (int i = 3; i >= 0; i--) begin
      if (peerHaltSeen[i] || peerRstSeen[i]) begin
        firstCpu = 2'(i);
      end
    end
  end

  always_comb begin
    r_d = r_q;
    irqSet = '0;
    r_d.ack = wbHit;
    r_d.haltS1 = peerIn.halt;
    r_d.haltS2 = r_q.haltS1;
    r_d.haltS3 = r_q.haltS2;
    r_d.rstS1 = peerIn.resetting;
    r_d.rstS2 = r_q.rstS1;
    r_d.rstS3 = r_q.rstS2;
    for (int i = 0; i < 4; i++) begin
      if (r_q.haltS2[i] == r_q.haltS3[i]) begin
        r_d.haltV[i] = r_q.haltS3[i];
      end
      if (r_q.rstS2[i] == r_q.rstS3[i]) begin
        r_d.rstV[i] = r_q.rstS3[i];
      end
    end
    // continuable program errors stop only their program
    r_d.prog = r_q.prog | NPROG'(errProg);
    if (|errProg) begin
      irqSet[`MCFP_IRQ_PROG] = 1'b1;
    end
    if (errDiagCont && r_q.cause == mcfp_pkg::MCFP_C_NONE) begin
      r_d.cause = mcfp_pkg::MCFP_C_DIAG_CONT;
    end
    if (errWdt) begin
      r_d.outForceOff = 1'b1;
      r_d.cause = mcfp_pkg::MCFP_C_WDT;
      r_d.code = `MCFP_CODE_MOTION;
      irqSet[`MCFP_IRQ_LOCAL] = 1'b1;
    end
    if (anyPeerCont && !r_q.peerErr) begin
      r_d.peerErr = 1'b1;
      if (!r_q.sysHalt) begin
        r_d.code = `MCFP_CODE_PEER_ERR;
        r_d.faultCpu = firstCpu;
      end
      irqSet[`MCFP_IRQ_PEERERR] = 1'b1;
    end
    case (r_q.st)
      mcfp_pkg::MCFP_RUN, mcfp_pkg::MCFP_STOPPED: begin
        if (errSysCfg) begin
          r_d.st = mcfp_pkg::MCFP_CFG_DEAD;
          r_d.outForceOff = 1'b1;
          r_d.cause = mcfp_pkg::MCFP_C_SYSCFG;
          r_d.code = `MCFP_CODE_MOTION;
          irqSet[`MCFP_IRQ_LOCAL] = 1'b1;
        end else if (errDiagFatal) begin
          // own halt goes out; peers decide by their selection
          r_d.st = mcfp_pkg::MCFP_HALTED;
          r_d.cause = mcfp_pkg::MCFP_C_DIAG_FATAL;
          r_d.code = `MCFP_CODE_MOTION;
          r_d.faultCpu = SELF_ID;
          irqSet[`MCFP_IRQ_LOCAL] = 1'b1;
        end else if (anyHaltAll) begin
          // detector raises its own halt, so cascades are possible
          r_d.st = mcfp_pkg::MCFP_HALTED;
          r_d.sysHalt = 1'b1;
          r_d.code = `MCFP_CODE_SYS_HALT;
          r_d.cause = mcfp_pkg::MCFP_C_PEER;
          r_d.faultCpu = firstCpu;
          irqSet[`MCFP_IRQ_SYSHALT] = 1'b1;
        end else begin
          r_d.st = r_q.runReq ? mcfp_pkg::MCFP_RUN
                              : mcfp_pkg::MCFP_STOPPED;
        end
      end
      mcfp_pkg::MCFP_HALTED: begin
        r_d.st = mcfp_pkg::MCFP_HALTED;
      end
      mcfp_pkg::MCFP_CFG_DEAD: begin
        r_d.st = mcfp_pkg::MCFP_CFG_DEAD;
      end
      default: begin
        r_d.st = mcfp_pkg::MCFP_STOPPED;
      end
    endcase
    if (wbHit && wbWeI && wbSelI[0]) begin
      case (wbAdrI)
        `MCFP_ADR_CTRL: begin
          r_d.runReq = wbDatI[0];
          r_d.haltSel = wbDatI[3:1];
        end
        `MCFP_ADR_IRQ: begin
          r_d.irqSt = r_q.irqSt & ~wbDatI[3:0];
        end
        `MCFP_ADR_MASK: begin
          r_d.irqMask = wbDatI[3:0];
        end
        default: begin
        end
      endcase
    end
    // set wins over a clear in the same cycle
    r_d.irqSt = r_d.irqSt | irqSet;
    r_d.dat = '0;
    if (wbHit && !wbWeI) begin
      case (wbAdrI)
        `MCFP_ADR_CTRL: r_d.dat = {28'h0, r_q.haltSel, r_q.runReq};
        `MCFP_ADR_STATUS: r_d.dat = {24'h0, r_q.st, 1'b0,
                                     r_q.outForceOff, r_q.peerErr,
                                     r_q.sysHalt};
        `MCFP_ADR_IRQ: r_d.dat = {28'h0, r_q.irqSt};
        `MCFP_ADR_MASK: r_d.dat = {28'h0, r_q.irqMask};
        `MCFP_ADR_CODE: r_d.dat = {16'h0, r_q.code};
        `MCFP_ADR_CAUSE: r_d.dat = {29'h0, r_q.cause};
        `MCFP_ADR_FAULTCPU: r_d.dat = {30'h0, r_q.faultCpu};
        `MCFP_ADR_EVENT: r_d.dat = {24'h0, r_q.prog};
        default: r_d.dat = '0;
      endcase
    end
  end

  // srst is the system reset from processor 1 or power-up
  always_ff @(posedge clk) begin
    if (srst) begin
      r_q <= '0;
      r_q.st <= mcfp_pkg::MCFP_STOPPED;
      r_q.haltSel <= `MCFP_HALTSEL_RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign wbAckO = r_q.ack;
  assign wbDatO = r_q.dat;
  assign selfHaltOut = (r_q.st == mcfp_pkg::MCFP_HALTED);
  assign runStateFlag = (r_q.st == mcfp_pkg::MCFP_RUN);
  // outputs retained on program errors, only watchdog/config force off
  assign outputsForceOff = r_q.outForceOff;
  assign progStop = r_q.prog;
  assign errCode = r_q.code;
  assign irq = |(r_q.irqSt & r_q.irqMask);
endmodule

// ### dv/mcfp_peer_model.sv
// peer processor model driving the shared halt and reset lines
`timescale 1ns/10ps
module mcfp_peer_model (
  input wire logic clk,
  input wire logic [3:0] haltCmd,
  input wire logic [3:0] rstCmd,
  output mcfp_pkg::mcfp_peer_t peerIn
);
  // peers switch on the same clk edge as the unit; the unit still resamples them
  always_ff @(posedge clk) begin
    peerIn.halt <= haltCmd;
    peerIn.resetting <= rstCmd;
  end
endmodule

// ### dv/mcfp_fault_unit_assertions.sv
// assertion checker for the fault propagation unit
`timescale 1ns/10ps
module mcfp_fault_unit_assertions #(
  parameter int NPROG = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire mcfp_pkg::mcfp_peer_t peerIn,
  input wire logic selfHaltOut,
  input wire logic errSysCfg,
  input wire logic errDiagFatal,
  input wire logic [NPROG-1:0] errProg,
  input wire logic runStateFlag,
  input wire logic outputsForceOff,
  input wire logic [NPROG-1:0] progStop,
  input wire logic [15:0] errCode,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence sysHaltSeen;
    selfHaltOut && errCode == 16'd7000 && !runStateFlag;
  endsequence
  a_master_halt: assert property ($rose(peerIn.halt[0]) && errCode == 16'h0
    |-> ##[1:8] sysHaltSeen) else $error("master halt not spread");
  a_peer_reset: assert property ($rose(peerIn.resetting[3]) && runStateFlag
    |-> ##[1:8] sysHaltSeen) else $error("peer reset not halting");
  a_halt_latched: assert property (selfHaltOut |=> selfHaltOut)
    else $error("halt indication dropped");
  a_halt_no_run: assert property (selfHaltOut |-> !runStateFlag)
    else $error("running while halted");
  a_cfg_off: assert property (errSysCfg |-> ##[1:3]
    (outputsForceOff && !runStateFlag && !selfHaltOut))
    else $error("config error response");
  a_diag_fatal: assert property (errDiagFatal && !outputsForceOff &&
    errCode == 16'h0 |-> ##[1:3] (selfHaltOut && errCode == 16'd10000))
    else $error("fatal diagnosis response");
  a_prog_stop: assert property (errProg != 0 && runStateFlag
    |-> ##[1:3] progStop != 0) else $error("program not stopped");
  a_reset_clear: assert property (disable iff (1'b0) srst
    |=> !selfHaltOut && errCode == 16'h0 && !irq) else $error("reset residue");
endmodule
bind mcfp_fault_unit mcfp_fault_unit_assertions #(.NPROG(NPROG)) chk_u (
  .clk, .srst, .peerIn, .selfHaltOut, .errSysCfg, .errDiagFatal, .errProg,
  .runStateFlag, .outputsForceOff, .progStop, .errCode, .irq);

// ### dv/multi_cpu_fault_propagation_tb.sv
// testbench for the multi-processor fault propagation unit
`timescale 1ns/10ps
module multi_cpu_fault_propagation_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, rd;
  logic ack, halt, run, off, irq;
  logic [3:0] err = 4'h0;
  logic [3:0] hc = 4'h0;
  logic [3:0] rc = 4'h0;
  logic [7:0] prog = 8'h0;
  logic [7:0] stop;
  logic [15:0] code;
  mcfp_pkg::mcfp_peer_t peer;
  int error_cnt = 0;
  int compares = 0;
  always #12.5 clk = ~clk;
  mcfp_peer_model peer_m (.clk(clk), .haltCmd(hc), .rstCmd(rc),
    .peerIn(peer));
  mcfp_fault_unit dut (.clk(clk), .srst(srst), .wbCycI(cyc), .wbStbI(stb),
    .wbWeI(we), .wbAdrI(adr), .wbSelI(4'hf), .wbDatI(wdat), .wbDatO(rdat),
    .wbAckO(ack), .peerIn(peer), .selfHaltOut(halt), .errSysCfg(err[0]),
    .errWdt(err[1]), .errDiagFatal(err[2]), .errDiagCont(err[3]),
    .errProg(prog), .runStateFlag(run), .outputsForceOff(off),
    .progStop(stop), .errCode(code), .irq(irq));
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("mismatches %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // each wait is bounded; mode 0 ack, 1 run, 2 code
  task automatic await(int m);
    int n;
    n = 0;
    while ((m == 0 ? ack : m == 1 ? run : code != 0) !== 1'b1) begin
      if (++n > 40) begin
        chk(32'h0, 32'h1);
        results();
      end
      @(posedge clk);
    end
  endtask
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    await(0);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic restart(logic [31:0] ctrl);
    srst <= 1'b1;
    hc <= 4'h0;
    rc <= 4'h0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk({halt, code}, 17'h0);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'he);
    bus(1'b1, 4'h0, ctrl);
    await(1);
  endtask
  task automatic t_peer(int k, logic [31:0] ctrl, bit viaRst, logic [15:0] x);
    restart(ctrl);
    if (viaRst) rc[k] <= 1'b1;
    else hc[k] <= 1'b1;
    await(2);
    @(posedge clk);
    chk(code, x);
    chk({halt, run}, x == 16'd7000 ? 2'b10 : 2'b01);
    bus(1'b0, 4'h6, 32'h0);
    chk(rd, k);
    hc <= 4'h0;
    rc <= 4'h0;
    repeat (8) @(posedge clk);
    chk(code, x);
  endtask
  task automatic t_local(logic [3:0] e, logic [7:0] p, logic [3:0] x,
      logic [3:0] m);
    restart(32'hf);
    err <= e;
    prog <= p;
    @(posedge clk);
    err <= 4'h0;
    prog <= 8'h0;
    repeat (4) @(posedge clk);
    chk({off, run, halt, stop[2]} & m, x);
    chk({off, run, halt, stop[2]} & m, x);
    if (e == 4'h4) chk(code, 16'd10000);
  endtask
  task automatic t_irq();
    logic a;
    t_peer(0, 32'hf, 1'b0, 16'd7000);
    bus(1'b1, 4'h3, 32'h0);
    @(posedge clk);
    a = irq;
    bus(1'b1, 4'h3, 32'hf);
    @(posedge clk);
    chk(a ^ irq, 1'b1);
    bus(1'b1, 4'h3, a ? 32'h0 : 32'hf);
    bus(1'b0, 4'h2, 32'h0);
    chk(rd[0], 1'b1);
    bus(1'b1, 4'h2, 32'h1);
    bus(1'b0, 4'h2, 32'h0);
    @(posedge clk);
    chk({rd[0], irq}, 2'b00);
    bus(1'b0, 4'hf, 32'h0);
    chk(rd, 32'h0);
  endtask
  initial begin
    t_peer(0, 32'hf, 1'b0, 16'd7000);
    t_peer(2, 32'hf, 1'b0, 16'd7000);
    t_peer(3, 32'h7, 1'b0, 16'd7020);
    t_peer(3, 32'h7, 1'b1, 16'd7000);
    t_local(4'h1, 8'h0, 4'b1000, 4'b1110);
    t_local(4'h2, 8'h0, 4'b1000, 4'b1000);
    t_local(4'h4, 8'h0, 4'b0010, 4'b0110);
    t_local(4'h8, 8'h0, 4'b0100, 4'b1111);
    t_local(4'h0, 8'h4, 4'b0101, 4'b1111);
    t_irq();
    results();
  end
endmodule
